/* vss_sequencer.sv */
`timescale 1ns/100ps
module vss_sequencer #(
  parameter int unsigned OC_DELAY = vss_pkg::OC_DELAY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enable_in,
  input  wire logic        second_phase_tied_high,
  input  wire logic        aux_boot_select_pin,
  input  wire logic        single_phase_strap_pos,
  input  wire logic        single_phase_strap_neg,
  input  wire logic        gate_driver_enable_in,
  output logic             gate_driver_enable_out,
  output logic             gate_driver_enable_oe,
  input  wire logic [2:0]  phase_pulse,
  input  wire logic        aux_pulse,
  input  wire logic [2:0]  phase_shed,
  input  wire logic        vcc_uv,
  input  wire logic        ramp_supply_sense_uv,
  input  wire logic        current_limit_sense_lo,
  input  wire logic        current_limit_sense_hi,
  input  wire logic        out_under_ready,
  input  wire logic        out_over_dac,
  input  wire logic        current_sense_reference_ov,
  input  wire logic        dynamic_voltage_change,
  output logic [5:0]       phase_drive,
  output logic [1:0]       aux_drive,
  output logic             test_current_en,
  output logic             comp_release,
  output logic [7:0]       dac_code,
  output logic [1:0]       core_phases,
  output logic             aux_enabled,
  output logic [1:0]       limit_scale,
  output logic             regulator_ready_out
);
  localparam int NS = 13;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  wire  [NS-1:0] raw = {enable_in, second_phase_tied_high, aux_boot_select_pin,
                        single_phase_strap_pos, single_phase_strap_neg,
                        gate_driver_enable_in, vcc_uv, ramp_supply_sense_uv,
                        current_limit_sense_lo, current_limit_sense_hi,
                        out_under_ready, out_over_dac, current_sense_reference_ov};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  wire en_s   = s2[12];
  wire p2_vcc = s2[11];
  wire ab_vcc = s2[10];
  wire sp_p   = s2[9];
  wire sp_n   = s2[8];
  wire drv_s  = s2[7];
  wire uv_in  = s2[6] | s2[5];
  wire oc_lo  = s2[4];
  wire oc_hi  = s2[3];
  wire uvo    = s2[2];
  wire ovd    = s2[1];
  wire ovr    = s2[0];

  vss_pkg::vss_state_t state;
  vss_pkg::vss_state_t next_state;
  logic [12:0] cnt;
  logic [15:0] oc_cnt;
  logic [7:0]  target;
  logic        soft_en;
  logic [2:0]  left_mid;
  logic        aux_left;
  logic        drv_seen_high;
  logic        oc_fault;
  logic        ov_fault;

  function automatic logic [1:0] lane(input logic active, input logic left,
                                      input vss_pkg::vss_state_t st);
    if (!active || st == vss_pkg::VSS_OFF || st == vss_pkg::VSS_DETECT)
      return vss_pkg::DRV_HIZ;
    if (st == vss_pkg::VSS_OV_RAMP || st == vss_pkg::VSS_OV_HOLD ||
        st == vss_pkg::VSS_OC_LATCH)
      return vss_pkg::DRV_LOW;
    // a restart into mid must not show a stale left-mid flag for a cycle
    return (left && st != vss_pkg::VSS_MID) ? vss_pkg::DRV_HIGH : vss_pkg::DRV_MID;
  endfunction : lane

  wire drv_drop  = drv_seen_high && !drv_s &&
                   (state == vss_pkg::VSS_SOFT || state == vss_pkg::VSS_RUN);
  wire oc_trip   = oc_hi || (oc_lo && oc_cnt >= OC_DELAY[15:0] - 16'h0001);
  wire ov_armed  = state == vss_pkg::VSS_RUN && !dynamic_voltage_change;
  wire ov_trip   = (ov_armed && ovd) || ovr;

  always_comb begin
    next_state = state;
    case (state)
      vss_pkg::VSS_OFF:    if (en_s && !uv_in) next_state = vss_pkg::VSS_DETECT;
      vss_pkg::VSS_DETECT: if (cnt == 13'(vss_pkg::DETECT_CYC - 1)) next_state = vss_pkg::VSS_MID;
      vss_pkg::VSS_MID:    if (cnt == 13'(vss_pkg::MID_CYC - 1)) next_state = vss_pkg::VSS_SOFT;
      vss_pkg::VSS_SOFT:   if (dac_code == target) next_state = vss_pkg::VSS_RUN;
      vss_pkg::VSS_RUN:    next_state = vss_pkg::VSS_RUN;
      vss_pkg::VSS_OV_RAMP: if (dac_code == vss_pkg::DAC_RST) next_state = vss_pkg::VSS_OV_HOLD;
      vss_pkg::VSS_OV_HOLD: next_state = vss_pkg::VSS_OV_HOLD;
      vss_pkg::VSS_OC_LATCH: next_state = vss_pkg::VSS_OC_LATCH;
      default:             next_state = vss_pkg::VSS_OFF;
    endcase
    if (state != vss_pkg::VSS_OFF && state != vss_pkg::VSS_DETECT &&
        state != vss_pkg::VSS_OV_RAMP && state != vss_pkg::VSS_OV_HOLD &&
        state != vss_pkg::VSS_OC_LATCH) begin
      if (drv_drop) next_state = vss_pkg::VSS_MID;
      if (ov_trip) next_state = vss_pkg::VSS_OV_RAMP;
      if (oc_trip) next_state = vss_pkg::VSS_OC_LATCH;
    end
    if (uv_in && state != vss_pkg::VSS_OV_HOLD && state != vss_pkg::VSS_OC_LATCH &&
        state != vss_pkg::VSS_OV_RAMP)
      next_state = vss_pkg::VSS_OFF;
    if (!en_s) next_state = vss_pkg::VSS_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= vss_pkg::VSS_OFF;
    else state <= next_state;
  end

  // shared step counter; restarts on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= '0;
    else if (next_state != state) cnt <= '0;
    else if (state == vss_pkg::VSS_SOFT && cnt == 13'(vss_pkg::SS_STEP_CYC - 1)) cnt <= '0;
    else cnt <= cnt + 13'h0001;
  end

  // the 50 us window only counts while the lower limit stays exceeded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oc_cnt <= '0;
    else if (!oc_lo || state != vss_pkg::VSS_RUN && state != vss_pkg::VSS_SOFT) oc_cnt <= '0;
    else if (oc_cnt != 16'hFFFF) oc_cnt <= oc_cnt + 16'h0001;
  end

  // strap decode latched when detection finishes, not at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_phases <= vss_pkg::CORE_3PH;
      aux_enabled <= 1'b1;
    end else if (state == vss_pkg::VSS_DETECT) begin
      if (sp_p && !sp_n) core_phases <= vss_pkg::CORE_1PH;
      else if (p2_vcc) core_phases <= vss_pkg::CORE_2PH;
      else core_phases <= vss_pkg::CORE_3PH;
      aux_enabled <= !ab_vcc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dac_code <= vss_pkg::DAC_RST;
    else if (state == vss_pkg::VSS_SOFT && cnt == 13'(vss_pkg::SS_STEP_CYC - 1) &&
             dac_code < target) dac_code <= dac_code + 8'h01;
    else if (state == vss_pkg::VSS_OV_RAMP && dac_code != vss_pkg::DAC_RST)
      dac_code <= dac_code - 8'h01;
    else if (state == vss_pkg::VSS_RUN && soft_en) dac_code <= target;
    else if (state == vss_pkg::VSS_OFF || state == vss_pkg::VSS_MID)
      dac_code <= vss_pkg::DAC_RST;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_mid <= '0;
      aux_left <= 1'b0;
    end else if (state != vss_pkg::VSS_SOFT && state != vss_pkg::VSS_RUN) begin
      left_mid <= '0;
      aux_left <= 1'b0;
    end else begin
      left_mid <= left_mid | phase_pulse;
      aux_left <= aux_left | aux_pulse;
    end
  end

  // ignore the driver line until it has been seen high once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drv_seen_high <= 1'b0;
    else if (state != vss_pkg::VSS_SOFT && state != vss_pkg::VSS_RUN) drv_seen_high <= 1'b0;
    else if (drv_s) drv_seen_high <= 1'b1;
  end

  logic [5:0] next_drive;
  always_comb begin
    next_drive = '0;
    for (int i = 0; i < vss_pkg::NUM_PHASE; i++)
      next_drive[2*i +: 2] = lane(32'(i) < 32'(core_phases), left_mid[i], state);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_drive <= {3{vss_pkg::DRV_HIZ}};
      aux_drive <= vss_pkg::DRV_HIZ;
      test_current_en <= 1'b0;
      comp_release <= 1'b0;
      gate_driver_enable_out <= 1'b0;
      gate_driver_enable_oe <= 1'b1;
      regulator_ready_out <= 1'b0;
      limit_scale <= '0;
    end else begin
      phase_drive <= next_drive;
      aux_drive <= lane(aux_enabled, aux_left, state);
      test_current_en <= state == vss_pkg::VSS_DETECT;
      comp_release <= state == vss_pkg::VSS_SOFT || state == vss_pkg::VSS_RUN;
      gate_driver_enable_out <= state == vss_pkg::VSS_SOFT || state == vss_pkg::VSS_RUN ||
                                state == vss_pkg::VSS_OV_RAMP || state == vss_pkg::VSS_OV_HOLD;
      // open drain: drive low only
      gate_driver_enable_oe <= !(state == vss_pkg::VSS_SOFT || state == vss_pkg::VSS_RUN ||
                                 state == vss_pkg::VSS_OV_RAMP || state == vss_pkg::VSS_OV_HOLD);
      regulator_ready_out <= state == vss_pkg::VSS_RUN && !uvo;
      limit_scale <= (core_phases > 2'(phase_shed[0] + phase_shed[1] + phase_shed[2])) ?
                     core_phases - 2'(phase_shed[0] + phase_shed[1] + phase_shed[2]) :
                     2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_fault <= 1'b0;
      ov_fault <= 1'b0;
    end else begin
      if (!en_s) oc_fault <= 1'b0;
      else if (next_state == vss_pkg::VSS_OC_LATCH) oc_fault <= 1'b1;
      if (!en_s) ov_fault <= 1'b0;
      else if (next_state == vss_pkg::VSS_OV_RAMP) ov_fault <= 1'b1;
    end
  end

  // APB slave, zero wait states
  wire acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target <= vss_pkg::TARGET_DEF;
      soft_en <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == vss_pkg::REG_CTRL) soft_en <= pwdata[0];
      if (paddr == vss_pkg::REG_TARGET) target <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != vss_pkg::REG_CTRL &&
                 paddr != vss_pkg::REG_TARGET && paddr != vss_pkg::REG_STATUS &&
                 paddr != vss_pkg::REG_DAC;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          vss_pkg::REG_CTRL:   prdata <= {31'h0, soft_en};
          vss_pkg::REG_TARGET: prdata <= {24'h0, target};
          vss_pkg::REG_STATUS: prdata <= {22'h0, oc_fault, ov_fault, aux_enabled,
                                          core_phases, 2'h0, state};
          vss_pkg::REG_DAC:    prdata <= {24'h0, dac_code};
          default:             prdata <= '0;
        endcase
      end
    end
  end

  property p_oc_hi;
    @(posedge pclk) disable iff (!presetn)
      (state == vss_pkg::VSS_RUN && oc_hi && en_s) |=> state == vss_pkg::VSS_OC_LATCH;
  endproperty
  a_oc_hi: assert property (p_oc_hi) else $error("high overcurrent not latched");

  property p_oc_hold;
    @(posedge pclk) disable iff (!presetn)
      (state == vss_pkg::VSS_OC_LATCH && en_s) |=> state == vss_pkg::VSS_OC_LATCH;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent latch left early");

  property p_ov_hold;
    @(posedge pclk) disable iff (!presetn)
      (state == vss_pkg::VSS_OV_HOLD && en_s) |=> state == vss_pkg::VSS_OV_HOLD;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overvoltage hold left early");

  property p_ov_ramp;
    @(posedge pclk) disable iff (!presetn)
      (state == vss_pkg::VSS_OV_RAMP && dac_code != 8'h00) |=> dac_code == $past(dac_code) - 8'h01;
  endproperty
  a_ov_ramp: assert property (p_ov_ramp) else $error("dac not ramping down");

  property p_drv_hold;
    @(posedge pclk) disable iff (!presetn)
      state == vss_pkg::VSS_OV_HOLD |=> gate_driver_enable_out && phase_drive == 6'h00;
  endproperty
  a_drv_hold: assert property (p_drv_hold) else $error("hold outputs wrong");

  property p_detect_hiz;
    @(posedge pclk) disable iff (!presetn)
      state == vss_pkg::VSS_DETECT |=> test_current_en && phase_drive == 6'h3F;
  endproperty
  a_detect_hiz: assert property (p_detect_hiz) else $error("detect outputs wrong");

  property p_ready_drop;
    @(posedge pclk) disable iff (!presetn) uvo |=> !regulator_ready_out;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready not dropped");

  sequence s_soft_step;
    state == vss_pkg::VSS_SOFT && cnt == 13'(vss_pkg::SS_STEP_CYC - 1) && dac_code < target;
  endsequence
  property p_soft;
    @(posedge pclk) disable iff (!presetn) s_soft_step |=> dac_code == $past(dac_code) + 8'h01;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start step missed");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (drv_drop && !ov_trip && !oc_trip && !uv_in && en_s) |=> state == vss_pkg::VSS_MID;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on driver drop");
endmodule : vss_sequencer

/* vss_pkg.sv */
package vss_pkg;
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned OC_DELAY_US     = 50;
  localparam int unsigned OC_DELAY_CYC    = OC_DELAY_US * CLK_MHZ;
  localparam int unsigned DETECT_CYC      = 16;
  localparam int unsigned MID_CYC         = 8;
  localparam int unsigned SS_STEP_CYC     = 4;
  localparam int unsigned GATE_DRIVER_ENABLE_LOW_CYC   = 4;
  localparam logic [7:0]  DAC_RST         = 8'h00;
  localparam logic [7:0]  TARGET_DEF      = 8'hC0;
  localparam int unsigned NUM_PHASE       = 3;
  // phase drive encoding
  localparam logic [1:0]  DRV_LOW         = 2'h0;
  localparam logic [1:0]  DRV_HIGH        = 2'h1;
  localparam logic [1:0]  DRV_MID         = 2'h2;
  localparam logic [1:0]  DRV_HIZ         = 2'h3;
  localparam logic [1:0]  CORE_1PH        = 2'h1;
  localparam logic [1:0]  CORE_2PH        = 2'h2;
  localparam logic [1:0]  CORE_3PH        = 2'h3;
  // APB register byte offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_TARGET      = 8'h04;
  localparam logic [7:0]  REG_STATUS      = 8'h08;
  localparam logic [7:0]  REG_DAC         = 8'h0C;
  typedef enum logic [2:0] {
    VSS_OFF, VSS_DETECT, VSS_MID, VSS_SOFT, VSS_RUN, VSS_OV_RAMP, VSS_OV_HOLD, VSS_OC_LATCH
  } vss_state_t;
endpackage : vss_pkg

/* vss_drv_model.sv */
`timescale 1ns/100ps
module vss_drv_model #(
  parameter int unsigned MIN_LOW = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic supply_bad,
  output logic      pull_low
);
  int unsigned cnt;
  // held low long enough for the controller to see it and restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 0;
      pull_low <= 1'b0;
    end else if (supply_bad) begin
      cnt      <= MIN_LOW;
      pull_low <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt      <= 0;
      pull_low <= 1'b0;
    end
  end
endmodule : vss_drv_model

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned OCD = 20;
  localparam logic [2:0] S_OFF = vss_pkg::VSS_OFF, S_DET = vss_pkg::VSS_DETECT,
    S_MID = vss_pkg::VSS_MID, S_SOFT = vss_pkg::VSS_SOFT, S_RUN = vss_pkg::VSS_RUN,
    S_OVR = vss_pkg::VSS_OV_RAMP, S_OVH = vss_pkg::VSS_OV_HOLD, S_OC = vss_pkg::VSS_OC_LATCH;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, dac_code;
  logic [31:0] pwdata, prdata;
  logic        enable_in, second_phase_tied_high, aux_boot_select_pin;
  logic        single_phase_strap_pos, single_phase_strap_neg, gate_driver_enable_in;
  logic        gate_driver_enable_out, gate_driver_enable_oe, aux_pulse, vcc_uv;
  logic        ramp_supply_sense_uv, current_limit_sense_lo, current_limit_sense_hi;
  logic        out_under_ready, out_over_dac, current_sense_reference_ov;
  logic        dynamic_voltage_change, test_current_en, comp_release, aux_enabled;
  logic        regulator_ready_out, supply_bad, pull_low;
  logic [2:0]  phase_pulse, phase_shed;
  logic [5:0]  phase_drive;
  logic [1:0]  aux_drive, core_phases, limit_scale;
  int          fail_count, cmp_count, cyc;
  // pull-up on the shared line: low if either party pulls it
  assign gate_driver_enable_in = !pull_low && !(gate_driver_enable_oe && !gate_driver_enable_out);
  vss_sequencer #(.OC_DELAY(OCD)) vss_sequencer_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .enable_in, .second_phase_tied_high, .aux_boot_select_pin, .single_phase_strap_pos,
    .single_phase_strap_neg, .gate_driver_enable_in, .gate_driver_enable_out,
    .gate_driver_enable_oe, .phase_pulse, .aux_pulse, .phase_shed, .vcc_uv,
    .ramp_supply_sense_uv, .current_limit_sense_lo, .current_limit_sense_hi,
    .out_under_ready, .out_over_dac, .current_sense_reference_ov, .dynamic_voltage_change,
    .phase_drive, .aux_drive, .test_current_en, .comp_release, .dac_code, .core_phases,
    .aux_enabled, .limit_scale, .regulator_ready_out);
  vss_drv_model vss_drv_model_i (.pclk, .presetn, .supply_bad, .pull_low);
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic tic(input int n);
    repeat (n) @(posedge pclk);
  endtask : tic
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // sampled at rising edges only; the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_st(input logic [2:0] s, input int lim);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, vss_pkg::REG_STATUS, 32'h0000_0000, r, e);
      n++;
    end while (r[2:0] !== s && n < lim);
    chk("state", s, r[2:0]);
  endtask : wait_st
  task automatic boot(input logic [3:0] c);
    enable_in <= 1'b0;
    tic(6);
    wait_st(S_OFF, 1);
    {second_phase_tied_high, aux_boot_select_pin} <= c[3:2];
    {single_phase_strap_pos, single_phase_strap_neg} <= c[1:0];
    enable_in <= 1'b1;
  endtask : boot
  task automatic t_reg;
    logic [31:0] r;
    logic        e;
    apb(1'b0, vss_pkg::REG_TARGET, 32'h0000_0000, r, e);
    chk("target", {24'h000000, vss_pkg::TARGET_DEF}, r);
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    chk("slverr", 32'h0000_0001, {31'h0, e});
    chk("unmapped", 32'h0000_0000, r);
    apb(1'b1, vss_pkg::REG_TARGET, 32'h0000_005A, r, e);
    apb(1'b0, vss_pkg::REG_TARGET, 32'h0000_0000, r, e);
    chk("target_wr", 32'h0000_005A, r);
    apb(1'b1, vss_pkg::REG_TARGET, {24'h000000, vss_pkg::TARGET_DEF}, r, e);
    apb(1'b1, 8'h10, 32'h0000_00FF, r, e);
    chk("slverr_wr", 32'h0000_0001, {31'h0, e});
    apb(1'b0, vss_pkg::REG_TARGET, 32'h0000_0000, r, e);
    chk("target_back", {24'h000000, vss_pkg::TARGET_DEF}, r);
  endtask : t_reg
  task automatic t_cfg;
    logic [6:0] t [7] = '{7'h07, 7'h45, 7'h26, 7'h64, 7'h53, 7'h0F, 7'h1F};
    for (int i = 0; i < 7; i++) begin
      boot(t[i][6:3]);
      wait_st(S_MID, 40);
      tic(2);
      chk("core", t[i][2:1], core_phases);
      chk("aux", t[i][0], aux_enabled);
    end
  endtask : t_cfg
  task automatic t_start;
    logic [7:0] d;
    boot(4'h0);
    wait_st(S_DET, 10);
    tic(2);
    chk("testcur", 1'b1, test_current_en);
    chk("hiz", 6'h3F, phase_drive);
    wait_st(S_MID, 20);
    tic(2);
    chk("mid", 6'h2A, phase_drive);
    chk("auxmid", vss_pkg::DRV_MID, aux_drive);
    chk("drv_early", 1'b0, gate_driver_enable_out);
    wait_st(S_SOFT, 20);
    tic(1);
    chk("drv_on", 1'b1, gate_driver_enable_in);
    chk("comp", 1'b1, comp_release);
    d = dac_code;
    tic(40);
    chk("slew", d + 8'h0A, dac_code);
    wait_st(S_RUN, 400);
    tic(2);
    chk("dac", vss_pkg::TARGET_DEF, dac_code);
    chk("hold_mid", 6'h2A, phase_drive);
    {phase_pulse, aux_pulse} <= 4'h3;
    tic(1);
    {phase_pulse, aux_pulse} <= 4'h0;
    tic(3);
    chk("left_mid", 6'h29, phase_drive);
    chk("aux_left", vss_pkg::DRV_HIGH, aux_drive);
  endtask : t_start
  task automatic t_mon;
    logic [31:0] r;
    logic        e;
    chk("ready", 1'b1, regulator_ready_out);
    out_under_ready <= 1'b1;
    tic(6);
    chk("ready_low", 1'b0, regulator_ready_out);
    out_under_ready <= 1'b0;
    phase_shed <= 3'h1;
    tic(3);
    chk("limit", 2'h2, limit_scale);
    phase_shed <= 3'h7;
    tic(3);
    chk("limit_min", 2'h1, limit_scale);
    phase_shed <= 3'h0;
    // direct target mode while regulating
    apb(1'b1, vss_pkg::REG_CTRL, 32'h0000_0001, r, e);
    apb(1'b0, vss_pkg::REG_CTRL, 32'h0000_0000, r, e);
    chk("ctrl", 32'h0000_0001, r);
    apb(1'b1, vss_pkg::REG_TARGET, 32'h0000_00A0, r, e);
    tic(2);
    chk("jump", 8'hA0, dac_code);
    apb(1'b1, vss_pkg::REG_TARGET, {24'h000000, vss_pkg::TARGET_DEF}, r, e);
    tic(2);
    chk("jump_back", vss_pkg::TARGET_DEF, dac_code);
    apb(1'b1, vss_pkg::REG_CTRL, 32'h0000_0000, r, e);
  endtask : t_mon
  task automatic t_restart;
    supply_bad <= 1'b1;
    tic(1);
    supply_bad <= 1'b0;
    wait_st(S_MID, 20);
    tic(1);
    chk("remid", 6'h2A, phase_drive);
    wait_st(S_SOFT, 40);
    wait_st(S_RUN, 400);
  endtask : t_restart
  task automatic t_oc;
    current_limit_sense_lo <= 1'b1;
    tic(OCD - 6);
    current_limit_sense_lo <= 1'b0;
    wait_st(S_RUN, 1);
    current_limit_sense_lo <= 1'b1;
    tic(OCD + 8);
    wait_st(S_OC, 1);
    chk("oc_low", 6'h00, phase_drive);
    current_limit_sense_lo <= 1'b0;
    tic(10);
    wait_st(S_OC, 1);
    boot(4'h0);
    wait_st(S_RUN, 400);
    current_limit_sense_hi <= 1'b1;
    tic(6);
    current_limit_sense_hi <= 1'b0;
    wait_st(S_OC, 1);
  endtask : t_oc
  task automatic t_ov;
    logic [7:0] d;
    boot(4'h0);
    wait_st(S_SOFT, 60);
    out_over_dac <= 1'b1;
    tic(10);
    wait_st(S_SOFT, 1);
    out_over_dac <= 1'b0;
    wait_st(S_RUN, 400);
    {dynamic_voltage_change, out_over_dac} <= 2'h3;
    tic(8);
    wait_st(S_RUN, 1);
    dynamic_voltage_change <= 1'b0;
    tic(4);
    chk("ov_low", 6'h00, phase_drive);
    wait_st(S_OVR, 1);
    d = dac_code;
    tic(10);
    chk("ramp", d - 8'h0A, dac_code);
    out_over_dac <= 1'b0;
    wait_st(S_OVH, 200);
    chk("dac0", 8'h00, dac_code);
    chk("hold_low", 6'h00, phase_drive);
    chk("drv_kept", 1'b1, gate_driver_enable_out);
    tic(10);
    wait_st(S_OVH, 1);
    boot(4'h0);
    wait_st(S_SOFT, 60);
    current_sense_reference_ov <= 1'b1;
    tic(5);
    current_sense_reference_ov <= 1'b0;
    wait_st(S_OVH, 20);
  endtask : t_ov
  task automatic t_uv;
    ramp_supply_sense_uv <= 1'b1;
    boot(4'h0);
    tic(30);
    wait_st(S_OFF, 1);
    ramp_supply_sense_uv <= 1'b0;
    wait_st(S_RUN, 500);
    vcc_uv <= 1'b1;
    tic(6);
    wait_st(S_OFF, 1);
    vcc_uv <= 1'b0;
  endtask : t_uv
  initial begin
    cyc        = 0;
    fail_count = 0;
    cmp_count  = 0;
    presetn <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {enable_in, second_phase_tied_high, aux_boot_select_pin, single_phase_strap_pos} <= '0;
    {single_phase_strap_neg, phase_pulse, aux_pulse, phase_shed, vcc_uv} <= '0;
    {ramp_supply_sense_uv, current_limit_sense_lo, current_limit_sense_hi} <= '0;
    {out_under_ready, out_over_dac, current_sense_reference_ov} <= '0;
    {dynamic_voltage_change, supply_bad} <= '0;
    tic(16);
    presetn <= 1'b1;
    t_reg();
    t_cfg();
    t_start();
    t_mon();
    t_restart();
    t_oc();
    t_ov();
    t_uv();
    close_out();
  end
endmodule : tb_top
